// File: src/dds_pkg.sv
// Purpose: Shared constants for the update and amplitude control block.
// Assumes: Byte-wide register port with 6-bit addresses, 200 MHz system clock.
// Notes: Bit positions inside control bytes are local choices where unspecified.
package dds_pkg;
  localparam logic [5:0] ADDR_PHASE1_HI = 6'h00;
  localparam logic [5:0] ADDR_PHASE1_LO = 6'h01;
  localparam logic [5:0] ADDR_PHASE2_HI = 6'h02;
  localparam logic [5:0] ADDR_PHASE2_LO = 6'h03;
  localparam logic [5:0] ADDR_UPD_B3 = 6'h16;
  localparam logic [5:0] ADDR_UPD_B0 = 6'h19;
  localparam logic [5:0] ADDR_RAMP_RATE = 6'h25;
  localparam logic [5:0] ADDR_PWR = 6'h1d;
  localparam logic [5:0] ADDR_UPD_CTL = 6'h1f;
  localparam logic [5:0] ADDR_KEY_CTL = 6'h20;
  localparam logic [5:0] ADDR_AMP_HI = 6'h21;
  localparam logic [5:0] ADDR_AMP_LO = 6'h22;
  localparam logic [5:0] ADDR_AUX_HI = 6'h26;
  localparam logic [5:0] ADDR_AUX_LO = 6'h27;
  localparam logic [5:0] ADDR_MEM_LAST = 6'h27;
  localparam int BIT_COS_PD = 2;
  localparam int BIT_AUX_PD = 1;
  localparam int BIT_INT_UPD = 0;
  localparam int BIT_MODE_LSB = 1;
  localparam int BIT_KEY_EN = 5;
  localparam int BIT_RAMP_INT = 4;
  localparam logic [7:0] RST_UPD_CTL = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [2:0] MODE_PHASE_KEY = 3'h4;
  localparam logic [31:0] UPD_PIN_MIN = 32'h0000_0005;
  localparam logic [7:0] RAMP_MIN = 8'h03;
  localparam logic [3:0] UPD_HIGH_CYC = 4'h8;
  localparam logic [11:0] AMP_FULL = 12'hfff;
  localparam logic [11:0] AMP_ZERO = 12'h000;
endpackage : dds_pkg

// File: src/dds_regmem.sv
// Purpose: Byte buffer memory written by the programming port.
// Assumes: One write or one read per clock.
// Notes: Read data is registered; entries clear at reset except the update control byte, which loads 01.
`timescale 1ns/1ps
module dds_regmem
  import dds_pkg::*;
#(
  parameter int DEPTH = 40
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [5:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic [8*DEPTH-1:0] flat
);
  logic [7:0] mem_reg [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_byte
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          mem_reg[gi] <= (6'(gi) == ADDR_UPD_CTL) ? RST_UPD_CTL : RST_ZERO;
        end else if (wr_en && addr == 6'(gi)) begin
          mem_reg[gi] <= wr_data;
        end
      end
      assign flat[8*gi +: 8] = mem_reg[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= RST_ZERO;
    end else begin
      rd_data <= (int'(addr) < DEPTH) ? mem_reg[addr] : RST_ZERO;
    end
  end
endmodule : dds_regmem

// File: src/dds_ctrl.sv
// Purpose: Update clock, phase-key select and shaped amplitude control.
// Assumes: Host pins are synchronous except the update pin, which is synchronised.
// Notes: Buffered bytes reach the active bank only on an update strobe.
`timescale 1ns/1ps
// Summary of operation
// - In phase-key mode, phase-select low uses first phase offset, high uses second; other modes use first.
// - Port writes land in a buffer, active only after transfer.
// - Transfer happens only on rising update edge, pin or internal counter.
// - External update edge is synchronised before use.
// - Internal/external select resets high; low makes pin an input.
// - Internal down-counter at half clock rate updates on reaching zero.
// - Update interval is (N+1) times two clock periods.
// - Internal update pulse drives pin high for eight clocks.
// - Count below 5 holds pin high while updates continue.
// - Keying disabled bypasses multiplier at full scale.
// - Internal-ramp bit selects ramp, else user 12-bit amplitude register.
// - 8-bit rate counter pulses at zero, each advancing 12-bit amplitude.
// - Multiplier scales proportionally over 4096 steps, zero gives zero.
// - Pulse spacing is count plus one clocks; count below 3 stalls.
// - Full ramp takes 4095 rate pulses.
// - Keying pin high ramps up and holds, low ramps down.
// - Cosine power-down bit powers down cosine converter.
// - Aux converter takes twos-complement 12-bit register value.
// - Aux power-down bit acts independently of cosine power-down.
module dds_ctrl
  import dds_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  input wire logic prog_wr,
  output logic [7:0] prog_rdata,
  input wire logic phase_select_pin,
  input wire logic keying_pin,
  input wire logic update_strobe_pin_in,
  output logic update_strobe_pin_out,
  output logic update_strobe_pin_oe,
  input wire logic signed [SAMPLE_W-1:0] cosine_sample,
  output logic signed [SAMPLE_W-1:0] cosine_dac_data,
  output logic [13:0] phase_offset,
  output logic cosine_dac_powerdown,
  output logic aux_dac_powerdown,
  output logic signed [11:0] aux_dac_data,
  output logic update_strobe
);
  localparam int DEPTH = int'(ADDR_MEM_LAST) + 1;

  logic [8*DEPTH-1:0] buf_flat;
  logic [8*DEPTH-1:0] act_reg;
  logic wr_en;

  assign wr_en = prog_wr;

  dds_regmem #(.DEPTH(DEPTH)) u_mem (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(wr_en),
    .addr(prog_addr),
    .wr_data(prog_wdata),
    .rd_data(prog_rdata),
    .flat(buf_flat)
  );

  function automatic logic [7:0] byte_at(input logic [8*DEPTH-1:0] v, input logic [5:0] a);
    byte_at = v[8*a +: 8];
  endfunction : byte_at

  // Control bytes of the active bank, split out so that single bits can be picked.
  logic [7:0] upd_ctl_byte;
  logic [7:0] key_ctl_byte;
  logic [7:0] pwr_byte;
  logic [7:0] ph1_hi_byte;
  logic [7:0] ph2_hi_byte;
  logic [7:0] amp_hi_byte;
  logic [7:0] aux_hi_byte;
  assign upd_ctl_byte = byte_at(act_reg, ADDR_UPD_CTL);
  assign key_ctl_byte = byte_at(act_reg, ADDR_KEY_CTL);
  assign pwr_byte = byte_at(act_reg, ADDR_PWR);
  assign ph1_hi_byte = byte_at(act_reg, ADDR_PHASE1_HI);
  assign ph2_hi_byte = byte_at(act_reg, ADDR_PHASE2_HI);
  assign amp_hi_byte = byte_at(act_reg, ADDR_AMP_HI);
  assign aux_hi_byte = byte_at(act_reg, ADDR_AUX_HI);

  // Update select and count come from the active bank, so a new count starts after an update.
  logic int_upd;
  logic [31:0] upd_count;
  assign int_upd = upd_ctl_byte[BIT_INT_UPD];
  assign upd_count = {byte_at(act_reg, ADDR_UPD_B3), byte_at(act_reg, 6'(ADDR_UPD_B3 + 6'h01)),
                      byte_at(act_reg, 6'(ADDR_UPD_B3 + 6'h02)), byte_at(act_reg, ADDR_UPD_B0)};

  // External update pin synchroniser and edge detect.
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= update_strobe_pin_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end
  logic ext_edge;
  assign ext_edge = ext_s2_reg && !ext_s3_reg && !int_upd;

  // Internal down-counter ticks every second clock.
  logic half_reg;
  logic [31:0] down_reg;
  logic int_tick;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= !half_reg;
    end
  end
  assign int_tick = int_upd && half_reg && (down_reg == 32'h0000_0000);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      down_reg <= 32'h0000_0000;
    end else if (!int_upd) begin
      down_reg <= upd_count;
    end else if (half_reg) begin
      down_reg <= (down_reg == 32'h0000_0000) ? upd_count : down_reg - 32'h0000_0001;
    end
  end

  assign update_strobe = ext_edge || int_tick;

  // Transfer buffer to active bank on update.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        act_reg[8*i +: 8] <= (6'(i) == ADDR_UPD_CTL) ? RST_UPD_CTL : RST_ZERO;
      end
    end else if (update_strobe) begin
      act_reg <= buf_flat;
    end
  end

  // Pin drive: eight-cycle high pulse, or held high for small counts.
  logic [3:0] hi_cnt_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_reg <= 4'h0;
    end else if (int_tick) begin
      hi_cnt_reg <= UPD_HIGH_CYC;
    end else if (hi_cnt_reg != 4'h0) begin
      hi_cnt_reg <= hi_cnt_reg - 4'h1;
    end
  end
  assign update_strobe_pin_oe = int_upd;
  assign update_strobe_pin_out = int_upd && ((hi_cnt_reg != 4'h0) || (upd_count < UPD_PIN_MIN));

  // Phase offset selection.
  logic [2:0] mode;
  logic [13:0] ph1, ph2;
  assign mode = upd_ctl_byte[BIT_MODE_LSB +: 3];
  assign ph1 = {ph1_hi_byte[5:0], byte_at(act_reg, ADDR_PHASE1_LO)};
  assign ph2 = {ph2_hi_byte[5:0], byte_at(act_reg, ADDR_PHASE2_LO)};
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_offset <= 14'h0000;
    end else begin
      phase_offset <= (mode == MODE_PHASE_KEY && phase_select_pin) ? ph2 : ph1;
    end
  end

  // Shaped keying ramp.
  logic key_en, ramp_int;
  logic [7:0] rate;
  logic [11:0] user_amp;
  assign key_en = key_ctl_byte[BIT_KEY_EN];
  assign ramp_int = key_ctl_byte[BIT_RAMP_INT];
  assign rate = byte_at(act_reg, ADDR_RAMP_RATE);
  assign user_amp = {amp_hi_byte[3:0], byte_at(act_reg, ADDR_AMP_LO)};

  logic [7:0] rate_reg;
  logic rate_pulse;
  assign rate_pulse = (rate >= RAMP_MIN) && (rate_reg == 8'h00);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rate_reg <= 8'h00;
    end else if (rate < RAMP_MIN) begin
      rate_reg <= rate_reg;
    end else if (rate_reg == 8'h00) begin
      rate_reg <= rate;
    end else begin
      rate_reg <= rate_reg - 8'h01;
    end
  end

  logic [11:0] amp_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      amp_reg <= AMP_ZERO;
    end else if (rate_pulse) begin
      if (keying_pin && amp_reg != AMP_FULL) begin
        amp_reg <= amp_reg + 12'h001;
      end else if (!keying_pin && amp_reg != AMP_ZERO) begin
        amp_reg <= amp_reg - 12'h001;
      end
    end
  end

  logic [11:0] scale;
  logic signed [SAMPLE_W+12:0] prod;
  assign scale = ramp_int ? amp_reg : user_amp;
  assign prod = cosine_sample * $signed({1'b0, scale});

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cosine_dac_data <= '0;
    end else if (!key_en) begin
      cosine_dac_data <= cosine_sample;
    end else begin
      cosine_dac_data <= prod[SAMPLE_W+11:12];
    end
  end

  // Converter controls.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cosine_dac_powerdown <= 1'b0;
      aux_dac_powerdown <= 1'b0;
      aux_dac_data <= 12'sh000;
    end else begin
      cosine_dac_powerdown <= pwr_byte[BIT_COS_PD];
      aux_dac_powerdown <= pwr_byte[BIT_AUX_PD];
      aux_dac_data <= {aux_hi_byte[3:0], byte_at(act_reg, ADDR_AUX_LO)};
    end
  end

  // Ramp, bypass and phase-select checks.
  a_ramp_saturate: assert property (@(posedge clk_sys) disable iff (!resetn)
    (amp_reg == AMP_FULL && keying_pin) |=> amp_reg == AMP_FULL)
    else $error("amplitude wrapped past full scale");

  a_ramp_stall: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rate < RAMP_MIN) |=> $stable(amp_reg))
    else $error("ramp advanced while stalled");

  a_amp_steady: assert property (@(posedge clk_sys) disable iff (!resetn)
    !rate_pulse |=> $stable(amp_reg))
    else $error("amplitude moved without a rate pulse");

  sequence s_min_rate_run;
    (rate_pulse && rate == RAMP_MIN) ##1 (rate == RAMP_MIN) [*4];
  endsequence

  a_rate_spacing: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_min_rate_run |-> rate_pulse)
    else $error("ramp pulse spacing not count plus one");

  a_bypass_full: assert property (@(posedge clk_sys) disable iff (!resetn)
    !key_en |=> cosine_dac_data == $past(cosine_sample))
    else $error("bypass not full scale");

  a_phase_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode != MODE_PHASE_KEY) |=> phase_offset == $past(ph1))
    else $error("phase pin acted outside keying mode");

  // Update path checks.
  a_ext_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
    (int_upd && !(half_reg && down_reg == 32'h0000_0000)) |-> !update_strobe)
    else $error("external edge used in internal mode");

  a_ext_sync: assert property (@(posedge clk_sys) disable iff (!resetn)
    ext_edge |-> $past(update_strobe_pin_in, 2) && !$past(update_strobe_pin_in, 3))
    else $error("external edge used before synchronising");

  a_bank_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !update_strobe |=> $stable(act_reg))
    else $error("active bank changed without update");

  // A pulse is only timed when the transfer leaves the bank as it was, since a new
  // count or mode may legitimately hold the pin high or release it.
  sequence s_quiet_tick;
    int_tick && (buf_flat == act_reg) && (upd_count >= UPD_PIN_MIN);
  endsequence
  sequence s_pin_pulse;
    update_strobe_pin_out [*8] ##1 !update_strobe_pin_out;
  endsequence

  a_pin_high_time: assert property (@(posedge clk_sys) disable iff (!resetn)
    int_tick |=> (update_strobe_pin_out || !int_upd) [*8])
    else $error("update pin high time short");

  a_pin_pulse_len: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_quiet_tick |=> s_pin_pulse)
    else $error("update pin pulse not eight cycles");

  a_pin_held_high: assert property (@(posedge clk_sys) disable iff (!resetn)
    (int_upd && upd_count < UPD_PIN_MIN) |-> update_strobe_pin_out)
    else $error("update pin dropped with short count");
endmodule : dds_ctrl

// File: testbench/dds_host_model.sv
// Purpose: Host model that drives the programming port and the keying pins.
// Assumes: Inputs change at the falling clock edge, one byte per write cycle.
// Notes: The update pin drive counts only while the device leaves the pin alone.
`timescale 1ns/1ps
module dds_host_model (
  input wire logic clk_sys,
  output logic [5:0] prog_addr,
  output logic [7:0] prog_wdata,
  output logic prog_wr,
  output logic phase_select_pin,
  output logic keying_pin,
  output logic pin_drv
);
  initial begin
    prog_addr = 6'h00;
    prog_wdata = 8'h00;
    prog_wr = 1'b0;
    phase_select_pin = 1'b0;
    keying_pin = 1'b0;
    pin_drv = 1'b0;
  end

  // Writes land in the buffer; the caller issues the update afterwards.
  task automatic write_byte(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    prog_addr = a;
    prog_wdata = d;
    prog_wr = 1'b1;
    @(negedge clk_sys);
    prog_wr = 1'b0;
  endtask : write_byte
endmodule : dds_host_model

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the update and amplitude control block.
// Assumes: 200 MHz clock, bench drives inputs at the falling edge.
// Notes: Expected values follow the register rules and the package constants.
`timescale 1ns/1ps
module tb_top;
  import dds_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0;
  logic [5:0] prog_addr;
  logic [7:0] prog_wdata, prog_rdata;
  logic prog_wr, phase_select_pin, keying_pin, pin_drv, pin_out, pin_oe, pin_lvl;
  logic signed [11:0] cosine_sample = 12'sh7ff;
  logic signed [11:0] cosine_dac_data, aux_dac_data;
  logic [13:0] phase_offset;
  logic cosine_dac_powerdown, aux_dac_powerdown, update_strobe;
  int fail_count = 0, num_checks = 0, st, hi;

  always #2.5 clk_sys = ~clk_sys;
  // The pin follows the device while it drives, otherwise the host.
  assign pin_lvl = pin_oe ? pin_out : pin_drv;

  dds_host_model dds_host_model_inst (.clk_sys(clk_sys), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_wr(prog_wr), .phase_select_pin(phase_select_pin),
    .keying_pin(keying_pin), .pin_drv(pin_drv));

  dds_ctrl dds_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_wr(prog_wr), .prog_rdata(prog_rdata),
    .phase_select_pin(phase_select_pin), .keying_pin(keying_pin),
    .update_strobe_pin_in(pin_lvl), .update_strobe_pin_out(pin_out),
    .update_strobe_pin_oe(pin_oe), .cosine_sample(cosine_sample),
    .cosine_dac_data(cosine_dac_data), .phase_offset(phase_offset),
    .cosine_dac_powerdown(cosine_dac_powerdown), .aux_dac_powerdown(aux_dac_powerdown),
    .aux_dac_data(aux_dac_data), .update_strobe(update_strobe));

  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    dds_host_model_inst.write_byte(a, d);
  endtask : wr

  task automatic wait_strobe;
    int i;
    for (i = 0; i < 100 && update_strobe !== 1'b1; i++) @(negedge clk_sys);
    if (i == 100) begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_strobe

  // Raises the update pin, holds it until the transfer is seen, then drops it.
  task automatic ext_update;
    @(negedge clk_sys);
    dds_host_model_inst.pin_drv = 1'b1;
    wait_strobe();
    @(negedge clk_sys);
    dds_host_model_inst.pin_drv = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : ext_update

  task automatic measure(input int n, output int s, output int h);
    s = 0;
    h = 0;
    repeat (n) begin
      @(negedge clk_sys);
      s += (update_strobe === 1'b1);
      h += (pin_out === 1'b1);
    end
  endtask : measure

  task automatic scen_buffer_power;
    wr(ADDR_UPD_CTL, 8'h00);
    repeat (10) @(negedge clk_sys);
    check("pin_oe_ext", pin_oe, 1'b0);
    wr(ADDR_AUX_HI, 8'h08);
    wr(ADDR_AUX_LO, 8'h00);
    wr(ADDR_PWR, 8'h04);
    @(negedge clk_sys);
    check("rdback_pwr", prog_rdata, 8'h04);
    repeat (6) @(negedge clk_sys);
    check("aux_buffered", $unsigned(aux_dac_data), 12'h000);
    check("cos_pd_buffered", cosine_dac_powerdown, 1'b0);
    ext_update();
    check("aux_data", $unsigned(aux_dac_data), 12'h800);
    check("cos_pd", {cosine_dac_powerdown, aux_dac_powerdown}, 2'b10);
    wr(ADDR_PWR, 8'h02);
    ext_update();
    check("aux_pd", {cosine_dac_powerdown, aux_dac_powerdown}, 2'b01);
  endtask : scen_buffer_power

  task automatic scen_phase;
    wr(ADDR_PHASE1_HI, 8'h01);
    wr(ADDR_PHASE1_LO, 8'h23);
    wr(ADDR_PHASE2_HI, 8'h3a);
    wr(ADDR_PHASE2_LO, 8'hbc);
    wr(ADDR_UPD_CTL, 8'h08);
    ext_update();
    repeat (3) @(negedge clk_sys);
    check("phase_low", phase_offset, 14'h0123);
    dds_host_model_inst.phase_select_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("phase_high", phase_offset, 14'h3abc);
    wr(ADDR_UPD_CTL, 8'h00);
    wr(ADDR_PHASE1_HI, 8'h04);
    wr(ADDR_PHASE1_LO, 8'h56);
    ext_update();
    repeat (3) @(negedge clk_sys);
    check("phase_single_tone", phase_offset, 14'h0456);
  endtask : scen_phase

  task automatic scen_keying;
    wr(ADDR_KEY_CTL, 8'h00);
    ext_update();
    check("bypass_full", $unsigned(cosine_dac_data), 12'h7ff);
    wr(ADDR_KEY_CTL, 8'h20);
    ext_update();
    check("user_amp_zero", $unsigned(cosine_dac_data), 12'h000);
    wr(ADDR_AMP_HI, 8'h08);
    wr(ADDR_AMP_LO, 8'h00);
    ext_update();
    check("user_amp_half", $unsigned(cosine_dac_data), 12'h3ff);
    wr(ADDR_KEY_CTL, 8'h30);
    wr(ADDR_RAMP_RATE, 8'h03);
    ext_update();
    repeat (100) @(negedge clk_sys);
    check("ramp_floor", $unsigned(cosine_dac_data), 12'h000);
    dds_host_model_inst.keying_pin = 1'b1;
    repeat (8000) @(negedge clk_sys);
    check("ramp_mid", cosine_dac_data < 12'sh7f0, 1'b1);
    repeat (8600) @(negedge clk_sys);
    check("ramp_top", cosine_dac_data >= 12'sh7f0, 1'b1);
    dds_host_model_inst.keying_pin = 1'b0;
    repeat (16600) @(negedge clk_sys);
    check("ramp_down", $unsigned(cosine_dac_data), 12'h000);
    wr(ADDR_RAMP_RATE, 8'h02);
    ext_update();
    dds_host_model_inst.keying_pin = 1'b1;
    repeat (2000) @(negedge clk_sys);
    check("ramp_stall", $unsigned(cosine_dac_data), 12'h000);
  endtask : scen_keying

  task automatic scen_update_clock;
    wr(ADDR_UPD_B3, 8'h00);
    wr(ADDR_UPD_B3 + 6'h01, 8'h00);
    wr(ADDR_UPD_B3 + 6'h02, 8'h00);
    wr(ADDR_UPD_B0, 8'h0a);
    wr(ADDR_UPD_CTL, 8'h01);
    ext_update();
    check("pin_oe_int", pin_oe, 1'b1);
    @(negedge clk_sys);
    wait_strobe();
    measure(22, st, hi);
    check("upd_interval", st, 1);
    check("upd_pin_high", hi, 8);
    wr(ADDR_UPD_B0, 8'h03);
    repeat (40) @(negedge clk_sys);
    measure(24, st, hi);
    check("short_strobes", st, 3);
    check("short_pin_high", hi, 24);
  endtask : scen_update_clock

  initial begin
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    check("rst_oe_out", {pin_oe, pin_out}, 2'b11);
    scen_buffer_power();
    scen_phase();
    scen_keying();
    scen_update_clock();
    report_and_stop();
  end
endmodule : tb_top
